// File: dap_pkg.sv
// shared types and constants for the arithmetic datapath
package dap_pkg;

    // apb register byte offsets
    localparam logic [7:0] DAP_OFS_CTRL = 8'h00;
    localparam logic [7:0] DAP_OFS_ACC = 8'h04;
    localparam logic [7:0] DAP_OFS_PROD = 8'h08;
    localparam logic [7:0] DAP_OFS_OPND = 8'h0C;
    localparam logic [7:0] DAP_OFS_STAT = 8'h10;

    // control register field positions
    localparam int DAP_CTRL_SXM = 0;
    localparam int DAP_CTRL_PSC_LO = 1;
    localparam int DAP_CTRL_UNS = 3;
    // status register field positions
    localparam int DAP_STAT_TEST = 0;
    localparam int DAP_STAT_NORM = 1;

    // reset values
    localparam logic DAP_RST_SXM = 1'b1;
    localparam logic [1:0] DAP_RST_PSC = 2'h0;
    localparam logic DAP_RST_UNS = 1'b0;

    // widths and shift limits
    localparam int DAP_DW = 16;
    localparam int DAP_AW = 32;
    localparam logic [4:0] DAP_MAX_SCALE = 5'h10;
    localparam int DAP_PSC_LEFT_A = 1;
    localparam int DAP_PSC_LEFT_B = 4;
    localparam int DAP_PSC_RIGHT = 6;

    // product output shift codes
    localparam logic [1:0] DAP_PSC_NONE = 2'h0;
    localparam logic [1:0] DAP_PSC_L1 = 2'h1;
    localparam logic [1:0] DAP_PSC_L4 = 2'h2;

    // datapath operations issued by the instruction decoder
    typedef enum logic [4:0] {
        DAP_NOP, DAP_LOAD, DAP_ADD, DAP_SUB, DAP_AND, DAP_OR, DAP_XOR,
        DAP_ADD_PROD, DAP_SUB_PROD, DAP_LOAD_PROD, DAP_LOAD_OPND,
        DAP_MULT, DAP_MAC, DAP_STORE_HI, DAP_STORE_LO, DAP_JUMP_ACC,
        DAP_NORM, DAP_BIT_TEST
    } dap_op_e;

    // one decoded instruction with its operands
    typedef struct packed {
        dap_op_e op;
        logic [15:0] data_word;
        logic [15:0] prog_word;
        logic [4:0] scale;
        logic [2:0] store_shift;
        logic [3:0] bit_sel;
    } dap_cmd_s;

    // results handed back to the bus and sequencer
    typedef struct packed {
        logic [15:0] store_word;
        logic store_valid;
        logic [15:0] branch_addr;
        logic branch_valid;
        logic test_flag;
    } dap_res_s;

    // apb slave answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dap_apb_s;

    // whole module state
    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] product_reg;
        logic [15:0] multiplier_operand_reg;
        logic sign_extend_mode_bit;
        logic [1:0] product_shift_code;
        logic mult_unsigned;
        logic norm_done;
        dap_res_s res;
        dap_apb_s apb;
    } dap_state_s;

endpackage : dap_pkg

// File: dap_datapath.sv
// alu, accumulator, scaling shifter and multiplier datapath with apb view
// Notes on behaviour
// RULE1 - 32-bit alu; accumulator first operand, product or scaled data second
// RULE2 - every alu result is written back into the accumulator
// RULE3 - accumulator is stored as separate high and low 16-bit words
// RULE4 - store path shifts the bus copy; accumulator keeps its contents
// RULE5 - scaling shifter takes 16-bit bus data, gives 32-bit alu operand
// RULE6 - scaling shift is 0 to 16 left, amount from instruction field
// RULE7 - vacated low bits of scaled value are zero
// RULE8 - upper bits zero or sign copies depending on sign extend mode bit
// RULE9 - 32-bit signed or unsigned product of two 16-bit words, one cycle
// RULE10 - 16-bit operand register holds one factor, other comes from a bus
// RULE11 - product register captures each result, feeds alu through shifter
// RULE12 - four selectable product output shift modes
// RULE13 - multiply-accumulate completes in one cycle using both buses
// RULE14 - accumulator supplies branch address on jump-to-accumulator
// RULE15 - normalise removes redundant sign bits of the accumulator
// RULE16 - test one selected bit of a data word for branch conditions
// RULE17 - product shift mode chosen by a 2-bit code
// RULE18 - store left shift comes from a 3-bit instruction field
// RULE19 - mac adds old shifted product while new product is captured
`timescale 1ns/100ps

module dap_datapath (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire dap_pkg::dap_cmd_s cmd,
    output dap_pkg::dap_res_s res
);
    import dap_pkg::*;

    dap_state_s st;
    dap_state_s next_st;

    logic [31:0] scaled;
    logic [31:0] prod_shifted;
    logic [31:0] new_product;
    logic [31:0] alu_b;
    logic [31:0] store_val;
    logic [31:0] rd_word;
    logic rd_hit;
    logic apb_take;

    // sign or zero extend, then shift; amounts past 16 saturate at 16
    always_comb begin
        logic [31:0] ext;
        logic [4:0] amt;
        ext = st.sign_extend_mode_bit ?
            {{DAP_DW{cmd.data_word[15]}}, cmd.data_word} :
            {{DAP_DW{1'b0}}, cmd.data_word}; // see RULE5 see RULE8
        amt = (cmd.scale > DAP_MAX_SCALE) ? DAP_MAX_SCALE : cmd.scale;
        scaled = ext << amt; // see RULE6 see RULE7
    end

    // product output shifter, right shift keeps the sign
    always_comb begin
        case (st.product_shift_code) // see RULE12 see RULE17
            DAP_PSC_NONE: prod_shifted = st.product_reg;
            DAP_PSC_L1: prod_shifted = st.product_reg << DAP_PSC_LEFT_A;
            DAP_PSC_L4: prod_shifted = st.product_reg << DAP_PSC_LEFT_B;
            default: prod_shifted = $signed(st.product_reg) >>> DAP_PSC_RIGHT;
        endcase
    end

    // multiplier; second factor is program word on mac, data word otherwise
    always_comb begin
        logic [15:0] fb;
        fb = (cmd.op == DAP_MAC) ? cmd.prog_word // see RULE10
            : cmd.data_word;
        if (st.mult_unsigned) begin
            new_product = st.multiplier_operand_reg * fb; // see RULE9
        end else begin
            new_product = $signed(st.multiplier_operand_reg) * $signed(fb);
        end
    end

    // second alu operand select
    always_comb begin
        case (cmd.op)
            DAP_ADD_PROD, DAP_SUB_PROD, DAP_LOAD_PROD, DAP_MAC: begin
                alu_b = prod_shifted; // see RULE1 see RULE11
            end
            default: alu_b = scaled; // see RULE1
        endcase
    end

    // shifted copy for a store; the accumulator itself is not touched
    assign store_val = st.acc << cmd.store_shift; // see RULE4 see RULE18

    // apb read mux; unmapped addresses answer with an error
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            DAP_OFS_CTRL: begin
                rd_word[DAP_CTRL_SXM] = st.sign_extend_mode_bit;
                rd_word[DAP_CTRL_PSC_LO +: 2] = st.product_shift_code;
                rd_word[DAP_CTRL_UNS] = st.mult_unsigned;
            end
            DAP_OFS_ACC: rd_word = st.acc;
            DAP_OFS_PROD: rd_word = st.product_reg;
            DAP_OFS_OPND: rd_word = {16'h0000, st.multiplier_operand_reg};
            DAP_OFS_STAT: begin
                rd_word[DAP_STAT_TEST] = st.res.test_flag;
                rd_word[DAP_STAT_NORM] = st.norm_done;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // one wait state: pready rises on the second access-phase cycle
    assign apb_take = psel && penable && st.apb.pready;

    // next state
    always_comb begin
        next_st = st;
        next_st.res.store_valid = 1'b0;
        next_st.res.branch_valid = 1'b0;

        // apb slave
        next_st.apb.pready = psel && penable && !st.apb.pready;
        if (psel && penable && !st.apb.pready) begin
            next_st.apb.prdata = (pwrite || !rd_hit) ? 32'h0000_0000 : rd_word;
            next_st.apb.pslverr = !rd_hit ||
                (pwrite && paddr != DAP_OFS_CTRL);
        end
        if (apb_take && pwrite && paddr == DAP_OFS_CTRL) begin
            next_st.sign_extend_mode_bit = pwdata[DAP_CTRL_SXM];
            next_st.product_shift_code = pwdata[DAP_CTRL_PSC_LO +: 2];
            next_st.mult_unsigned = pwdata[DAP_CTRL_UNS];
        end

        // datapath command
        if (cmd_valid) begin
            case (cmd.op)
                DAP_LOAD: next_st.acc = scaled; // see RULE2
                DAP_ADD: next_st.acc = st.acc + alu_b; // see RULE2
                DAP_SUB: next_st.acc = st.acc - alu_b;
                DAP_AND: next_st.acc = st.acc & alu_b;
                DAP_OR: next_st.acc = st.acc | alu_b;
                DAP_XOR: next_st.acc = st.acc ^ alu_b;
                DAP_ADD_PROD: next_st.acc = st.acc + alu_b;
                DAP_SUB_PROD: next_st.acc = st.acc - alu_b;
                DAP_LOAD_PROD: next_st.acc = alu_b;
                DAP_LOAD_OPND: begin
                    next_st.multiplier_operand_reg = cmd.data_word;
                end
                DAP_MULT: next_st.product_reg = new_product; // see RULE11
                DAP_MAC: begin
                    // old product accumulates while the new one lands
                    next_st.acc = st.acc + alu_b; // see RULE13 see RULE19
                    next_st.multiplier_operand_reg = cmd.data_word;
                    next_st.product_reg = new_product; // see RULE13
                end
                DAP_STORE_HI: begin
                    next_st.res.store_word = store_val[31:16]; // see RULE3
                    next_st.res.store_valid = 1'b1;
                end
                DAP_STORE_LO: begin
                    next_st.res.store_word = store_val[15:0]; // see RULE3
                    next_st.res.store_valid = 1'b1;
                end
                DAP_JUMP_ACC: begin
                    next_st.res.branch_addr = st.acc[15:0]; // see RULE14
                    next_st.res.branch_valid = 1'b1;
                end
                DAP_NORM: begin
                    // one sign bit per step; sequencer repeats until done
                    if (st.acc != 32'h0000_0000 &&
                            st.acc[31] == st.acc[30]) begin
                        next_st.acc = st.acc << 1; // see RULE15
                        next_st.norm_done = 1'b0;
                    end else begin
                        next_st.norm_done = 1'b1; // see RULE15
                    end
                end
                DAP_BIT_TEST: begin
                    next_st.res.test_flag =
                        cmd.data_word[cmd.bit_sel]; // see RULE16
                end
                // nop and unknown codes leave the state alone
                default: ;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.sign_extend_mode_bit <= DAP_RST_SXM;
            st.product_shift_code <= DAP_RST_PSC;
            st.mult_unsigned <= DAP_RST_UNS;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign prdata = st.apb.prdata;
    assign pready = st.apb.pready;
    assign pslverr = st.apb.pslverr;
    assign res = st.res;

endmodule : dap_datapath

// File: dap_decoder_model.sv
// instruction decoder model issuing one command per request
`timescale 1ns/100ps
module dap_decoder_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire dap_pkg::dap_cmd_s req_cmd,
    output logic cmd_valid,
    output dap_pkg::dap_cmd_s cmd
);
    import dap_pkg::*;
    // one-cycle strobe; idle fields toggle so stale values never look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid <= 1'b0;
            cmd <= '0;
        end else begin
            cmd_valid <= go;
            cmd <= go ? req_cmd : ~cmd;
        end
    end
endmodule : dap_decoder_model

// File: dap_datapath_chk.sv
// port checker for the arithmetic datapath
`timescale 1ns/100ps
module dap_datapath_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmd_valid,
    input wire dap_pkg::dap_cmd_s cmd,
    input wire dap_pkg::dap_res_s res
);
    import dap_pkg::*;
    logic st, jp, bt, exp_bit;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded command kinds
    assign st = cmd_valid && cmd.op inside {DAP_STORE_HI, DAP_STORE_LO};
    assign jp = cmd_valid && cmd.op == DAP_JUMP_ACC;
    assign bt = cmd_valid && cmd.op == DAP_BIT_TEST;
    // selected bit kept for the cycle the flag shows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) exp_bit <= 1'b0;
        else exp_bit <= cmd.data_word[cmd.bit_sel];
    end
    a_store_pulse: assert property (st |=> res.store_valid)
        else $error("store pulse missing");
    a_store_cause: assert property (res.store_valid |-> $past(st))
        else $error("store pulse without store");
    a_store_hold: assert property (
        !st |=> $stable(res.store_word)) else $error("store word moved");
    a_jump_pulse: assert property (jp |=> res.branch_valid)
        else $error("branch pulse missing");
    a_branch_hold: assert property (
        !jp |=> $stable(res.branch_addr)) else $error("branch address moved");
    a_test_flag: assert property (
        bt |=> res.test_flag == exp_bit) else $error("test flag wrong");
    a_test_hold: assert property (!bt |=> $stable(res.test_flag))
        else $error("test flag moved");
    a_apb_wait: assert property (psel && !penable ##1 psel && penable
        |-> !pready ##1 pready) else $error("apb wait state wrong");
    cover property (st);
    cover property (bt ##1 res.test_flag);
    cover property (pready && pslverr);
endmodule : dap_datapath_chk

// File: dap_datapath_test.sv
// self-checking bench for the arithmetic datapath
`timescale 1ns/100ps
module dap_datapath_test;
    import dap_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, acc, p, rd;
    logic pready, pslverr, err, cmd_valid;
    logic go = 1'b0;
    dap_cmd_s req_cmd = '0;
    dap_cmd_s cmd;
    dap_res_s res;
    int errors = 0;
    int n_checks = 0;
    integer seed = 35830;
    logic [15:0] a, b;
    int i, s;
    // operations not reached by the scaling and product scenarios
    dap_op_e ops [7] = '{DAP_SUB, DAP_AND, DAP_OR, DAP_XOR, DAP_SUB_PROD,
        DAP_LOAD_PROD, DAP_NOP};
    always #10 pclk = ~pclk;
    dap_datapath dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd(cmd), .res(res));
    dap_decoder_model u_dec (.pclk(pclk), .presetn(presetn), .go(go),
        .req_cmd(req_cmd), .cmd_valid(cmd_valid), .cmd(cmd));
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : check
    // apb transfer; waits for pready, then releases and idles one cycle
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here; only the watchdog ends a wait that hangs
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(dap_op_e o, logic [15:0] d, logic [15:0] pw,
            logic [4:0] sc, logic [2:0] ss, logic [3:0] bs);
        go <= 1'b1;
        req_cmd <= '{o, d, pw, sc, ss, bs};
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : op
    function automatic logic [31:0] scl(logic [15:0] d, int n, logic sx);
        return (sx ? {{16{d[15]}}, d} : {16'h0, d}) << n;
    endfunction : scl
    // plain vectors so the arithmetic shift is not lost to sign rules
    function automatic logic [31:0] psh(logic [31:0] v, int k);
        return k == 0 ? v : k == 1 ? v << 1 : k == 2 ? v << 4
            : {{6{v[31]}}, v[31:6]};
    endfunction : psh
    // expected accumulator for the remaining operations
    function automatic logic [31:0] alu(int k, logic [31:0] x,
            logic [31:0] y, logic [31:0] q);
        case (k)
            0: return x - y;
            1: return x & y;
            2: return x | y;
            3: return x ^ y;
            4: return x - q;
            5: return q;
            default: return x;
        endcase
    endfunction : alu
    function automatic logic [31:0] mul(logic [15:0] x, logic [15:0] y,
            logic u);
        return u ? {16'h0, x} * {16'h0, y}
            : {{16{x[15]}}, x} * {{16{y[15]}}, y};
    endfunction : mul
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        errors++;
        $display("[ERR] watchdog exp finish got timeout");
        conclude();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, DAP_OFS_CTRL, 32'h0);
        check("ctrl reset", 32'h1, rd);
        apb(1'b1, DAP_OFS_ACC, 32'hFFFFFFFF);
        check("ro write err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        // scaling shifter, edge amounts first
        for (i = 0; i < 10; i++) begin
            s = (i < 2) ? i * 16 : $unsigned($random(seed)) % 17;
            a = $random(seed);
            b = $random(seed);
            apb(1'b1, DAP_OFS_CTRL, {31'h0, i[0]});
            op(DAP_LOAD, a, 16'h0, 5'(s), 3'h0, 4'h0);
            op(DAP_ADD, b, 16'h0, 5'h0, 3'h0, 4'h0);
            acc = scl(a, s, i[0]) + scl(b, 0, i[0]);
            apb(1'b0, DAP_OFS_ACC, 32'h0);
            check("acc scaled", acc, rd);
        end
        // every product shift code, codes 0 and 2 signed, codes 1 and 3 unsigned
        for (i = 0; i < 4; i++) begin
            a = $random(seed);
            b = $random(seed);
            apb(1'b1, DAP_OFS_CTRL, {28'h0, i[0], i[1:0], 1'b1});
            op(DAP_LOAD_OPND, a, 16'h0, 5'h0, 3'h0, 4'h0);
            op(DAP_MULT, b, 16'h0, 5'h0, 3'h0, 4'h0);
            p = mul(a, b, i[0]);
            apb(1'b0, DAP_OFS_PROD, 32'h0);
            check("product", p, rd);
            op(DAP_LOAD, 16'h0, 16'h0, 5'h0, 3'h0, 4'h0);
            op(DAP_ADD_PROD, 16'h0, 16'h0, 5'h0, 3'h0, 4'h0);
            apb(1'b0, DAP_OFS_ACC, 32'h0);
            check("acc product", psh(p, i), rd);
        end
        acc = psh(p, 3);
        apb(1'b1, DAP_OFS_CTRL, 32'h1);
        b = $random(seed);
        op(DAP_MAC, 16'h1234, b, 5'h0, 3'h0, 4'h0);
        acc = acc + p;
        p = mul(a, b, 1'b0);
        apb(1'b0, DAP_OFS_ACC, 32'h0);
        check("mac acc", acc, rd);
        apb(1'b0, DAP_OFS_PROD, 32'h0);
        check("mac product", p, rd);
        apb(1'b0, DAP_OFS_OPND, 32'h0);
        check("operand", 32'h1234, rd);
        for (i = 0; i < 8; i++) begin
            op(i[0] ? DAP_STORE_HI : DAP_STORE_LO, 16'h0, 16'h0, 5'h0,
                3'(i), 4'h0);
            rd = acc << i;
            rd = i[0] ? {16'h0, rd[31:16]} : {16'h0, rd[15:0]};
            check("store", rd, res.store_word);
        end
        apb(1'b0, DAP_OFS_ACC, 32'h0);
        check("acc kept", acc, rd);
        op(DAP_JUMP_ACC, 16'h0, 16'h0, 5'h0, 3'h0, 4'h0);
        check("branch", acc[15:0], res.branch_addr);
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            s = $unsigned($random(seed)) % 16;
            op(DAP_BIT_TEST, a, 16'h0, 5'h0, 3'h0, 4'(s));
            check("bit test", a[s], res.test_flag);
        end
        op(DAP_LOAD, 16'h1, 16'h0, 5'h0, 3'h0, 4'h0);
        repeat (30) op(DAP_NORM, 16'h0, 16'h0, 5'h0, 3'h0, 4'h0);
        apb(1'b0, DAP_OFS_ACC, 32'h0);
        check("normalised", 32'h40000000, rd);
        // one more step finds bits 31 and 30 apart and raises done
        op(DAP_NORM, 16'h0, 16'h0, 5'h0, 3'h0, 4'h0);
        apb(1'b0, DAP_OFS_STAT, 32'h0);
        check("status", {30'h0, 1'b1, a[s]}, rd);
        // remaining alu codes; product register still holds p, shift none
        for (i = 0; i < 7; i++) begin
            a = $random(seed);
            b = $random(seed);
            op(DAP_LOAD, a, 16'h0, 5'h0, 3'h0, 4'h0);
            op(ops[i], b, 16'h0, 5'h0, 3'h0, 4'h0);
            acc = alu(i, scl(a, 0, 1'b1), scl(b, 0, 1'b1), p);
            apb(1'b0, DAP_OFS_ACC, 32'h0);
            check("alu op", acc, rd);
        end
        conclude();
    end
endmodule : dap_datapath_test
bind dap_datapath dap_datapath_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .res(res));
